// File: design/dgp_consts.svh
// Register offsets, reset values and pin masks of the debug-capable GPIO port
// Summary of operation
// - Eight-bit port, each pin's direction set by its own bit.
// - Reset puts pins 3 to 7 into their debug alternate functions.
// - Pin 3 as TMS/SWDIO gets input, output driver and pull-up enabled.
// - Pin 4 as TCK/SWCLK gets input and pull-down enabled.
// - Pin 5 as TDO or viewer output gets its output driver enabled.
// - Pin 6 as TDI gets input and pull-up enabled.
// - Pin 7 as TRST input gets its pull-up enabled.
// - Pins 0 to 2 reset as plain GPIO with all buffers and pulls off.
// - Pin 3 as TMS/SWDIO keeps driving in STOP regardless of drive-keep bit.
// - Data, output-enable and function-select registers at 0x00, 0x04, 0x08.
// - Open-drain 0x28, pull-up 0x2C, pull-down 0x30, input-enable 0x38.
// - Data register is written in bits 7-0, resets zero; reads show the pin where input is enabled; bits 31-8 read zero.
// - Output-enable bit 1 drives pin, 0 floats it; pins 5 and 3 reset set.
// - Function-select bit 1 picks alternate function; bits 7 to 3 reset set.
// - Function-select bits 2, 1, 0 route trace data 1, data 0, clock.
// - Open-drain bit 0 gives push-pull, 1 open-drain; all reset zero.
// - Pull-up bit 1 enables pull-up; pins 7, 6, 3 reset set.
// - Pull-down bit 1 enables pull-down; only pin 4 resets set.
// - Input-enable bit 1 enables input buffer; pins 7, 6, 4, 3 reset set.
`ifndef DGP_CONSTS_SVH
`define DGP_CONSTS_SVH

`define DGP_ADDR_W      12
`define DGP_OFS_DATA    12'h000
`define DGP_OFS_OE      12'h004
`define DGP_OFS_FSEL    12'h008
`define DGP_OFS_OD      12'h028
`define DGP_OFS_PU      12'h02c
`define DGP_OFS_PD      12'h030
`define DGP_OFS_IE      12'h038

`define DGP_RST_DATA    8'h00
`define DGP_RST_OE      8'h28
`define DGP_RST_FSEL    8'hf8
`define DGP_RST_OD      8'h00
`define DGP_RST_PU      8'hc8
`define DGP_RST_PD      8'h10
`define DGP_RST_IE      8'hd8

`define DGP_FORCE_OE    8'h28
`define DGP_FORCE_IE    8'h58
`define DGP_FORCE_PU    8'hc8
`define DGP_FORCE_PD    8'h10
`define DGP_KEEP_STOP   8'h08

`define DGP_BIT_TCLK    0
`define DGP_BIT_TD0     1
`define DGP_BIT_TD1     2
`define DGP_BIT_TMS     3
`define DGP_BIT_TCK     4
`define DGP_BIT_TDO     5
`define DGP_BIT_TDI     6
`define DGP_BIT_TRST    7

`endif

// File: design/dgp_pkg.sv
// Types shared by the debug-capable GPIO port
package dgp_pkg;

	typedef enum logic [1:0] {
		DGP_IDLE = 2'b00,
		DGP_RESP = 2'b01
	} dgp_apb_state_t;

	typedef enum logic [2:0] {
		DGP_SEL_DATA = 3'h0,
		DGP_SEL_OE   = 3'h1,
		DGP_SEL_FSEL = 3'h2,
		DGP_SEL_OD   = 3'h3,
		DGP_SEL_PU   = 3'h4,
		DGP_SEL_PD   = 3'h5,
		DGP_SEL_IE   = 3'h6,
		DGP_SEL_NONE = 3'h7
	} dgp_reg_sel_t;

	typedef struct packed {
		dgp_apb_state_t apb;
		logic [7:0]     data;
		logic [7:0]     oe;
		logic [7:0]     fsel;
		logic [7:0]     od;
		logic [7:0]     pu;
		logic [7:0]     pd;
		logic [7:0]     ie;
		logic           pready;
		logic           pslverr;
		logic [31:0]    prdata;
		logic           tms;
		logic           tck;
		logic           tdi;
		logic           trst_n;
	} dgp_state_t;

endpackage : dgp_pkg

// File: design/dgp_sync.sv
// Two-stage synchroniser for pin inputs
`timescale 1ns/100ps
`default_nettype none
module dgp_sync #(
	parameter int W = 8
) (
	input  wire logic         pclk,
	input  wire logic         presetn,
	input  wire logic [W-1:0] d,
	output var  logic [W-1:0] q
);
	typedef struct packed {
		logic [W-1:0] s1;
		logic [W-1:0] s2;
	} dgp_sync_t;

	dgp_sync_t st_reg;
	dgp_sync_t st_next;

	// First stage feeds only the second
	always_comb
	begin
		st_next.s1 = d;
		st_next.s2 = st_reg.s1;
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			st_reg <= '0;
		else
			st_reg <= st_next;
	end

	assign q = st_reg.s2;
endmodule : dgp_sync
`default_nettype wire

// File: design/dgp_pad_ctl.sv
// Registered pad control for one port pin
`timescale 1ns/100ps
`default_nettype none
module dgp_pad_ctl #(
	parameter logic FORCE_OE = 1'b0,
	parameter logic FORCE_IE = 1'b0,
	parameter logic FORCE_PU = 1'b0,
	parameter logic FORCE_PD = 1'b0,
	parameter logic KEEP_STOP = 1'b0
) (
	input  wire logic pclk,
	input  wire logic presetn,
	input  wire logic gpio_out,
	input  wire logic alt_out,
	input  wire logic alt_sel,
	input  wire logic oe,
	input  wire logic od,
	input  wire logic pu,
	input  wire logic pd,
	input  wire logic ie,
	input  wire logic stop_kill,
	output var  logic pad_out,
	output var  logic pad_oe,
	output var  logic pad_pu,
	output var  logic pad_pd,
	output var  logic pad_ie
);
	typedef struct packed {
		logic out;
		logic oe;
		logic pu;
		logic pd;
		logic ie;
	} dgp_pad_t;

	dgp_pad_t st_reg;
	dgp_pad_t st_next;
	logic     drv;

	always_comb
	begin
		st_next.out = alt_sel ? alt_out : gpio_out;
		drv = oe | (alt_sel & FORCE_OE);
		// Open drain only ever pulls low
		if (od && st_next.out)
			drv = 1'b0;
		if (stop_kill && !(alt_sel && KEEP_STOP))
			drv = 1'b0;
		st_next.oe = drv;
		st_next.pu = pu | (alt_sel & FORCE_PU);
		st_next.pd = pd | (alt_sel & FORCE_PD);
		st_next.ie = ie | (alt_sel & FORCE_IE);
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			st_reg <= '0;
		else
			st_reg <= st_next;
	end

	assign pad_out = st_reg.out;
	assign pad_oe  = st_reg.oe;
	assign pad_pu  = st_reg.pu;
	assign pad_pd  = st_reg.pd;
	assign pad_ie  = st_reg.ie;
endmodule : dgp_pad_ctl
`default_nettype wire

// File: design/dgp_port.sv
// Debug-capable eight-bit GPIO port with APB register slave
`timescale 1ns/100ps
`default_nettype none
`include "dgp_consts.svh"
module dgp_port #(
	parameter int ADDR_W = `DGP_ADDR_W
) (
	input  wire logic              pclk,
	input  wire logic              presetn,
	input  wire logic              psel,
	input  wire logic              penable,
	input  wire logic              pwrite,
	input  wire logic [ADDR_W-1:0] paddr,
	input  wire logic [31:0]       pwdata,
	output var  logic              pready,
	output var  logic              pslverr,
	output var  logic [31:0]       prdata,
	input  wire logic [7:0]        pin_in,
	output var  logic [7:0]        pin_out,
	output var  logic [7:0]        pin_oe,
	output var  logic [7:0]        pin_pu,
	output var  logic [7:0]        pin_pd,
	output var  logic [7:0]        pin_ie,
	input  wire logic              stop_mode,
	input  wire logic              standby_drive_keep,
	input  wire logic              swdio_out,
	input  wire logic              tdo_out,
	input  wire logic              trace_clock_out,
	input  wire logic              trace_data_bit0,
	input  wire logic              trace_data_bit1,
	output var  logic              dbg_tms_in,
	output var  logic              dbg_tck_in,
	output var  logic              dbg_tdi_in,
	output var  logic              dbg_trst_n_in
);
	dgp_pkg::dgp_state_t   st_reg;
	dgp_pkg::dgp_state_t   st_next;
	dgp_pkg::dgp_reg_sel_t sel;
	logic [7:0]            pin_sync;
	logic [7:0]            pin_seen;
	logic [7:0]            alt_out;
	logic                  stop_kill;
	logic                  wr_done;

	function automatic dgp_pkg::dgp_reg_sel_t reg_decode(input logic [ADDR_W-1:0] a);
		if (a == ADDR_W'(`DGP_OFS_DATA))
			return dgp_pkg::DGP_SEL_DATA;
		else if (a == ADDR_W'(`DGP_OFS_OE))
			return dgp_pkg::DGP_SEL_OE;
		else if (a == ADDR_W'(`DGP_OFS_FSEL))
			return dgp_pkg::DGP_SEL_FSEL;
		else if (a == ADDR_W'(`DGP_OFS_OD))
			return dgp_pkg::DGP_SEL_OD;
		else if (a == ADDR_W'(`DGP_OFS_PU))
			return dgp_pkg::DGP_SEL_PU;
		else if (a == ADDR_W'(`DGP_OFS_PD))
			return dgp_pkg::DGP_SEL_PD;
		else if (a == ADDR_W'(`DGP_OFS_IE))
			return dgp_pkg::DGP_SEL_IE;
		else
			return dgp_pkg::DGP_SEL_NONE;
	endfunction : reg_decode

	dgp_sync #(
		.W(8)
	) u_sync (
		.pclk   (pclk),
		.presetn(presetn),
		.d      (pin_in),
		.q      (pin_sync)
	);

	// Input buffer off reads as low
	assign pin_seen  = pin_sync & pin_ie;
	assign stop_kill = stop_mode & ~standby_drive_keep;
	assign sel       = reg_decode(paddr);
	assign wr_done   = psel & penable & st_reg.pready & pwrite;

	always_comb
	begin
		alt_out                 = 8'h00;
		alt_out[`DGP_BIT_TCLK]  = trace_clock_out;
		alt_out[`DGP_BIT_TD0]   = trace_data_bit0;
		alt_out[`DGP_BIT_TD1]   = trace_data_bit1;
		alt_out[`DGP_BIT_TMS]   = swdio_out;
		alt_out[`DGP_BIT_TDO]   = tdo_out;
	end

	genvar gi;
	generate
		for (gi = 0; gi < 8; gi++)
		begin : g_pad
			dgp_pad_ctl #(
				.FORCE_OE (logic'(((`DGP_FORCE_OE) >> gi) & 8'h01)),
				.FORCE_IE (logic'(((`DGP_FORCE_IE) >> gi) & 8'h01)),
				.FORCE_PU (logic'(((`DGP_FORCE_PU) >> gi) & 8'h01)),
				.FORCE_PD (logic'(((`DGP_FORCE_PD) >> gi) & 8'h01)),
				.KEEP_STOP(logic'(((`DGP_KEEP_STOP) >> gi) & 8'h01))
			) u_pad (
				.pclk     (pclk),
				.presetn  (presetn),
				.gpio_out (st_reg.data[gi]),
				.alt_out  (alt_out[gi]),
				.alt_sel  (st_reg.fsel[gi]),
				.oe       (st_reg.oe[gi]),
				.od       (st_reg.od[gi]),
				.pu       (st_reg.pu[gi]),
				.pd       (st_reg.pd[gi]),
				.ie       (st_reg.ie[gi]),
				.stop_kill(stop_kill),
				.pad_out  (pin_out[gi]),
				.pad_oe   (pin_oe[gi]),
				.pad_pu   (pin_pu[gi]),
				.pad_pd   (pin_pd[gi]),
				.pad_ie   (pin_ie[gi])
			);
		end
	endgenerate

	always_comb
	begin
		st_next         = st_reg;
		st_next.pready  = 1'b0;
		st_next.pslverr = 1'b0;
		case (st_reg.apb)
			dgp_pkg::DGP_IDLE:
			begin
				if (psel && !penable)
				begin
					// One wait-free access cycle; answer is built in setup
					st_next.apb     = dgp_pkg::DGP_RESP;
					st_next.pready  = 1'b1;
					st_next.pslverr = (sel == dgp_pkg::DGP_SEL_NONE);
					st_next.prdata  = 32'h0000_0000;
					if (!pwrite)
					begin
						if (sel == dgp_pkg::DGP_SEL_DATA)
							st_next.prdata[7:0] = pin_seen | (st_reg.data & ~pin_ie);
						else if (sel == dgp_pkg::DGP_SEL_OE)
							st_next.prdata[7:0] = st_reg.oe;
						else if (sel == dgp_pkg::DGP_SEL_FSEL)
							st_next.prdata[7:0] = st_reg.fsel;
						else if (sel == dgp_pkg::DGP_SEL_OD)
							st_next.prdata[7:0] = st_reg.od;
						else if (sel == dgp_pkg::DGP_SEL_PU)
							st_next.prdata[7:0] = st_reg.pu;
						else if (sel == dgp_pkg::DGP_SEL_PD)
							st_next.prdata[7:0] = st_reg.pd;
						else if (sel == dgp_pkg::DGP_SEL_IE)
							st_next.prdata[7:0] = st_reg.ie;
					end
				end
			end
			dgp_pkg::DGP_RESP:
			begin
				st_next.apb = dgp_pkg::DGP_IDLE;
				if (wr_done)
				begin
					if (sel == dgp_pkg::DGP_SEL_DATA)
						st_next.data = pwdata[7:0];
					else if (sel == dgp_pkg::DGP_SEL_OE)
						st_next.oe = pwdata[7:0];
					else if (sel == dgp_pkg::DGP_SEL_FSEL)
						st_next.fsel = pwdata[7:0];
					else if (sel == dgp_pkg::DGP_SEL_OD)
						st_next.od = pwdata[7:0];
					else if (sel == dgp_pkg::DGP_SEL_PU)
						st_next.pu = pwdata[7:0];
					else if (sel == dgp_pkg::DGP_SEL_PD)
						st_next.pd = pwdata[7:0];
					else if (sel == dgp_pkg::DGP_SEL_IE)
						st_next.ie = pwdata[7:0];
				end
			end
			default:
			begin
				st_next.apb = dgp_pkg::DGP_IDLE;
			end
		endcase
		// Debug inputs only see the pin while it is in debug use
		st_next.tms    = st_reg.fsel[`DGP_BIT_TMS] & pin_seen[`DGP_BIT_TMS];
		st_next.tck    = st_reg.fsel[`DGP_BIT_TCK] & pin_seen[`DGP_BIT_TCK];
		st_next.tdi    = st_reg.fsel[`DGP_BIT_TDI] & pin_seen[`DGP_BIT_TDI];
		// Pull-up alone holds reset released; TRST input is taken unbuffered
		st_next.trst_n = ~st_reg.fsel[`DGP_BIT_TRST] | pin_sync[`DGP_BIT_TRST];
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			st_reg         <= '0;
			st_reg.apb     <= dgp_pkg::DGP_IDLE;
			st_reg.data    <= `DGP_RST_DATA;
			st_reg.oe      <= `DGP_RST_OE;
			st_reg.fsel    <= `DGP_RST_FSEL;
			st_reg.od      <= `DGP_RST_OD;
			st_reg.pu      <= `DGP_RST_PU;
			st_reg.pd      <= `DGP_RST_PD;
			st_reg.ie      <= `DGP_RST_IE;
			st_reg.trst_n  <= 1'b1;
		end
		else
			st_reg <= st_next;
	end

	assign pready        = st_reg.pready;
	assign pslverr       = st_reg.pslverr;
	assign prdata        = st_reg.prdata;
	assign dbg_tms_in    = st_reg.tms;
	assign dbg_tck_in    = st_reg.tck;
	assign dbg_tdi_in    = st_reg.tdi;
	assign dbg_trst_n_in = st_reg.trst_n;

	// Marks the first cycle after reset release
	logic first_reg;
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			first_reg <= 1'b1;
		else
			first_reg <= 1'b0;
	end

	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);

	sequence s_setup;
		psel && !penable;
	endsequence

	sequence s_write_done(logic [ADDR_W-1:0] ofs);
		psel && penable && pready && pwrite && paddr == ofs;
	endsequence

	sequence s_read_at(logic [ADDR_W-1:0] ofs);
		psel && !penable && !pwrite && paddr == ofs;
	endsequence

	a_reset_regs: assert property (first_reg |-> st_reg.fsel == 8'hf8 && st_reg.oe == 8'h28
		&& st_reg.pu == 8'hc8 && st_reg.pd == 8'h10 && st_reg.ie == 8'hd8 && st_reg.od == 8'h00)
		else $error("register reset values wrong");
	a_gpio_low_off: assert property (first_reg |-> st_reg.fsel[2:0] == 3'b000
		&& st_reg.oe[2:0] == 3'b000 && st_reg.ie[2:0] == 3'b000 && st_reg.pu[2:0] == 3'b000)
		else $error("low pins not plain gpio after reset");
	a_apb_answer: assert property (s_setup |=> pready ##1 !pready)
		else $error("apb answer not exactly one access cycle");
	a_unmapped_err: assert property (s_setup and (paddr == ADDR_W'(12'h00c)) |=> pslverr && prdata == 32'h0000_0000)
		else $error("unmapped address not refused");
	a_upper_zero: assert property (pready |-> prdata[31:8] == 24'h00_0000)
		else $error("upper read bits not zero");
	a_data_write: assert property (s_write_done(ADDR_W'(12'h000)) |=> st_reg.data == $past(pwdata[7:0]))
		else $error("data register write lost");
	a_pd_write: assert property (s_write_done(ADDR_W'(12'h030)) |=> st_reg.pd == $past(pwdata[7:0]))
		else $error("pull-down register write lost");
	a_tms_pad: assert property (st_reg.fsel[3] && !st_reg.od[3] |=> pin_oe[3] && pin_ie[3] && pin_pu[3])
		else $error("swdio pad not enabled");
	a_tms_stop: assert property (st_reg.fsel[3] && !st_reg.od[3] && stop_mode && !standby_drive_keep |=> pin_oe[3])
		else $error("swdio driver dropped in stop");
	a_tck_pad: assert property (st_reg.fsel[4] |=> pin_ie[4] && pin_pd[4])
		else $error("swclk pad not enabled");
	a_tdo_pad: assert property (st_reg.fsel[5] && !st_reg.od[5] && !stop_kill |=> pin_oe[5] && pin_out[5] == $past(tdo_out))
		else $error("tdo pad not driven");
	a_tdi_pad: assert property (st_reg.fsel[6] |=> pin_ie[6] && pin_pu[6])
		else $error("tdi pad not enabled");
	a_trst_pad: assert property (st_reg.fsel[7] |=> pin_pu[7])
		else $error("trst pull-up missing");
	a_gpio_oe: assert property (!st_reg.fsel[0] && !st_reg.od[0] && !stop_kill |=> pin_oe[0] == $past(st_reg.oe[0]))
		else $error("gpio output enable not followed");
	a_stop_off: assert property (!st_reg.fsel[1] && stop_kill |=> !pin_oe[1])
		else $error("driver kept in stop without drive-keep");
	a_trace_route: assert property (st_reg.fsel[0] |=> pin_out[0] == $past(trace_clock_out))
		else $error("trace clock not routed");
	a_gpio_data: assert property (!st_reg.fsel[2] ##1 !st_reg.fsel[2] |-> pin_out[2] == $past(st_reg.data[2]))
		else $error("gpio data not on pin");
	a_open_drain: assert property (st_reg.od[1] |=> !(pin_oe[1] && pin_out[1]))
		else $error("open drain drove high");
	a_ie_gate: assert property (!pin_ie[6] |=> !dbg_tdi_in)
		else $error("disabled input buffer passed data");
	a_fsel_write: assert property (s_write_done(ADDR_W'(12'h008)) |=> st_reg.fsel == $past(pwdata[7:0]))
		else $error("function select write lost");
	a_pu_write: assert property (s_write_done(ADDR_W'(12'h02c)) |=> st_reg.pu == $past(pwdata[7:0]))
		else $error("pull-up register write lost");
	a_oe_write: assert property (s_write_done(ADDR_W'(12'h004)) |=> st_reg.oe == $past(pwdata[7:0]))
		else $error("output enable write lost");
	a_od_write: assert property (s_write_done(ADDR_W'(12'h028)) |=> st_reg.od == $past(pwdata[7:0]))
		else $error("open drain write lost");
	a_ie_write: assert property (s_write_done(ADDR_W'(12'h038)) |=> st_reg.ie == $past(pwdata[7:0]))
		else $error("input enable write lost");
	a_wr_refused: assert property (s_write_done(ADDR_W'(12'h00c)) |=> $stable(st_reg.data))
		else $error("unmapped write landed");
	a_read_oe: assert property (s_read_at(ADDR_W'(12'h004)) |=> prdata[7:0] == $past(st_reg.oe))
		else $error("output enable read wrong");
	a_read_fsel: assert property (s_read_at(ADDR_W'(12'h008)) |=> prdata[7:0] == $past(st_reg.fsel))
		else $error("function select read wrong");
	a_read_od: assert property (s_read_at(ADDR_W'(12'h028)) |=> prdata[7:0] == $past(st_reg.od))
		else $error("open drain read wrong");
	a_read_pu: assert property (s_read_at(ADDR_W'(12'h02c)) |=> prdata[7:0] == $past(st_reg.pu))
		else $error("pull-up read wrong");
	a_read_pd: assert property (s_read_at(ADDR_W'(12'h030)) |=> prdata[7:0] == $past(st_reg.pd))
		else $error("pull-down read wrong");
	a_read_ie: assert property (s_read_at(ADDR_W'(12'h038)) |=> prdata[7:0] == $past(st_reg.ie))
		else $error("input enable read wrong");
	a_data_masked: assert property (s_read_at(ADDR_W'(12'h000)) |=>
		(prdata[7:0] | $past(pin_ie)) == ($past(st_reg.data) | $past(pin_ie)))
		else $error("data read lost register bits");
	a_mapped_ok: assert property (s_setup and (paddr == ADDR_W'(12'h004)) |=> !pslverr)
		else $error("mapped address refused");
	a_ready_idle: assert property (!psel |=> !pready)
		else $error("pready without request");
	a_rst_outputs: assert property (first_reg |-> !pready && !pslverr
		&& prdata == 32'h0000_0000 && dbg_trst_n_in)
		else $error("outputs not idle after reset");
	a_low_pulls: assert property (first_reg |-> st_reg.pd[2:0] == 3'b000 && st_reg.od[2:0] == 3'b000)
		else $error("low pins pulled after reset");
	a_pu_follow: assert property (!st_reg.fsel[0] |=> pin_pu[0] == $past(st_reg.pu[0]))
		else $error("pull-up not on pad");
	a_pd_follow: assert property (!st_reg.fsel[4] |=> pin_pd[4] == $past(st_reg.pd[4]))
		else $error("pull-down not on pad");
	a_ie_follow: assert property (!st_reg.fsel[1] |=> pin_ie[1] == $past(st_reg.ie[1]))
		else $error("input enable not on pad");
	a_gpio_dir: assert property (!st_reg.fsel[7] && !st_reg.od[7] && !stop_kill
		|=> pin_oe[7] == $past(st_reg.oe[7]))
		else $error("pin direction not followed");
	a_keep_drive: assert property (stop_mode && standby_drive_keep && !st_reg.od[6]
		|=> pin_oe[6] == $past(st_reg.oe[6]))
		else $error("drive-keep dropped a driver");
	a_td0_route: assert property (st_reg.fsel[1] |=> pin_out[1] == $past(trace_data_bit0))
		else $error("trace data 0 not routed");
	a_td1_route: assert property (st_reg.fsel[2] |=> pin_out[2] == $past(trace_data_bit1))
		else $error("trace data 1 not routed");
	a_swdio_route: assert property (st_reg.fsel[3] |=> pin_out[3] == $past(swdio_out))
		else $error("swdio output not routed");
	a_tms_seen: assert property (st_reg.fsel[3] && pin_ie[3] |=> dbg_tms_in == $past(pin_sync[3]))
		else $error("tms input not seen");
	a_tck_seen: assert property (st_reg.fsel[4] && pin_ie[4] |=> dbg_tck_in == $past(pin_sync[4]))
		else $error("tck input not seen");
	a_tdi_seen: assert property (st_reg.fsel[6] && pin_ie[6] |=> dbg_tdi_in == $past(pin_sync[6]))
		else $error("tdi input not seen");
	a_trst_seen: assert property (st_reg.fsel[7] |=> dbg_trst_n_in == $past(pin_sync[7]))
		else $error("trst input not seen");
	a_trst_idle: assert property (!st_reg.fsel[7] |=> dbg_trst_n_in)
		else $error("trst asserted in gpio use");
	a_tck_gate: assert property (!st_reg.fsel[4] |=> !dbg_tck_in)
		else $error("tck seen in gpio use");
	a_tms_gate: assert property (!st_reg.fsel[3] |=> !dbg_tms_in)
		else $error("tms seen in gpio use");
endmodule : dgp_port
`default_nettype wire

// File: dv/dgp_pin_model.sv
// Board-side pad model: resolves each pin from drivers, pulls and the probe
`timescale 1ns/100ps
`default_nettype none
module dgp_pin_model (
	input  wire logic       pclk,
	input  wire logic [7:0] pin_out,
	input  wire logic [7:0] pin_oe,
	input  wire logic [7:0] pin_pu,
	input  wire logic [7:0] pin_pd,
	input  wire logic [7:0] probe_en,
	input  wire logic [7:0] probe_val,
	output var  logic [7:0] pin_in
);
	initial pin_in = 8'h00;
	// Floating pins toggle so that no stale level passes for a real one
	always @(posedge pclk)
	begin
		for (int i = 0; i < 8; i++)
		begin
			if (probe_en[i])
				pin_in[i] <= probe_val[i];
			else if (pin_oe[i])
				pin_in[i] <= pin_out[i];
			else if (pin_pu[i])
				pin_in[i] <= 1'b1;
			else if (pin_pd[i])
				pin_in[i] <= 1'b0;
			else
				pin_in[i] <= ~pin_in[i];
		end
	end
endmodule : dgp_pin_model
`default_nettype wire

// File: dv/test_dgp_port.sv
// Self-checking bench for the debug-capable GPIO port
`timescale 1ns/100ps
`default_nettype none
module test_dgp_port;
	logic        pclk = 1'b0;
	logic        presetn, psel, penable, pwrite, pready, pslverr, err;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata, rd;
	logic [7:0]  pin_in, pin_out, pin_oe, pin_pu, pin_pd, pin_ie, probe_en, probe_val;
	logic        stop_mode, standby_drive_keep, swdio_out, tdo_out;
	logic        trace_clock_out, trace_data_bit0, trace_data_bit1;
	logic        dbg_tms_in, dbg_tck_in, dbg_tdi_in, dbg_trst_n_in;
	int          fails, tests_run, cycles;

	always #2 pclk = ~pclk;

	dgp_port i_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .pready(pready), .pslverr(pslverr), .prdata(prdata),
		.pin_in(pin_in), .pin_out(pin_out), .pin_oe(pin_oe), .pin_pu(pin_pu), .pin_pd(pin_pd),
		.pin_ie(pin_ie), .stop_mode(stop_mode), .standby_drive_keep(standby_drive_keep),
		.swdio_out(swdio_out), .tdo_out(tdo_out), .trace_clock_out(trace_clock_out),
		.trace_data_bit0(trace_data_bit0), .trace_data_bit1(trace_data_bit1),
		.dbg_tms_in(dbg_tms_in), .dbg_tck_in(dbg_tck_in), .dbg_tdi_in(dbg_tdi_in),
		.dbg_trst_n_in(dbg_trst_n_in));

	dgp_pin_model i_pins (.pclk(pclk), .pin_out(pin_out), .pin_oe(pin_oe), .pin_pu(pin_pu),
		.pin_pd(pin_pd), .probe_en(probe_en), .probe_val(probe_val), .pin_in(pin_in));

	task automatic report_and_stop();
		$display("checks %0d mismatches %0d", tests_run, fails);
		if (fails == 0 && tests_run > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask : report_and_stop

	// Hang guard, well above the few hundred cycles the tests need
	always @(posedge pclk)
	begin
		cycles++;
		if (cycles == 5000)
		begin
			fails++;
			report_and_stop();
		end
	end

	// Request held until pready is seen high at a rising edge; only the hang guard ends a wait
	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		@(posedge pclk);
		psel    <= 1'b1;
		penable <= 1'b0;
		pwrite  <= w;
		paddr   <= a;
		pwdata  <= d;
		@(posedge pclk);
		penable <= 1'b1;
		@(posedge pclk);
		while (pready !== 1'b1)
			@(posedge pclk);
		rd  = prdata;
		err = pslverr;
		psel    <= 1'b0;
		penable <= 1'b0;
	endtask : apb

	task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
		tests_run++;
		if (got !== exp)
		begin
			fails++;
			$display("ERROR %s expected %h seen %h", what, exp, got);
		end
	endtask : chk

	task automatic chk8(input string what, input logic [7:0] exp, input logic [7:0] got);
		chk(what, {24'h00_0000, exp}, {24'h00_0000, got});
	endtask : chk8

	task automatic rd_chk(input string what, input logic [11:0] a, input logic [31:0] exp);
		apb(1'b0, a, 32'h0000_0000);
		chk(what, exp, rd);
	endtask : rd_chk

	task automatic settle(input int c);
		repeat (c) @(negedge pclk);
	endtask : settle

	task automatic t_reset();
		rd_chk("oe_rst", 12'h004, 32'h0000_0028);
		rd_chk("fsel_rst", 12'h008, 32'h0000_00f8);
		rd_chk("od_rst", 12'h028, 32'h0000_0000);
		rd_chk("pu_rst", 12'h02c, 32'h0000_00c8);
		rd_chk("pd_rst", 12'h030, 32'h0000_0010);
		rd_chk("ie_rst", 12'h038, 32'h0000_00d8);
		rd_chk("data_rst", 12'h000, 32'h0000_00c0);
		settle(1);
		chk8("pin_oe_rst", 8'h28, pin_oe);
		chk8("pin_pu_rst", 8'hc8, pin_pu);
		chk8("pin_pd_rst", 8'h10, pin_pd);
		chk8("pin_ie_rst", 8'hd8, pin_ie);
		$display("test reset done");
	endtask : t_reset

	task automatic t_regs();
		logic [11:0] ofs [6] = '{12'h004, 12'h008, 12'h028, 12'h02c, 12'h030, 12'h038};
		foreach (ofs[i])
		begin
			apb(1'b1, ofs[i], 32'hffff_ff5a);
			rd_chk("reg_rw", ofs[i], 32'h0000_005a);
			apb(1'b1, ofs[i], 32'h0000_0000);
		end
		apb(1'b1, 12'h000, 32'hffff_ffa5);
		rd_chk("data_rw", 12'h000, 32'h0000_00a5);
		apb(1'b1, 12'h00c, 32'hffff_ffff);
		chk8("err_wr", 8'h01, {7'h00, err});
		rd_chk("unmapped_rd", 12'h03c, 32'h0000_0000);
		chk8("err_rd", 8'h01, {7'h00, err});
		rd_chk("data_kept", 12'h000, 32'h0000_00a5);
		$display("test registers done");
	endtask : t_regs

	task automatic t_gpio_out();
		apb(1'b1, 12'h004, 32'h0000_00ff);
		settle(3);
		chk8("pin_out", 8'ha5, pin_out);
		chk8("pin_oe_all", 8'hff, pin_oe);
		apb(1'b1, 12'h028, 32'h0000_000f);
		settle(3);
		chk8("pin_oe_od", 8'hfa, pin_oe);
		apb(1'b1, 12'h028, 32'h0000_0000);
		apb(1'b1, 12'h004, 32'h0000_000f);
		settle(3);
		chk8("pin_oe_half", 8'h0f, pin_oe);
		$display("test gpio output done");
	endtask : t_gpio_out

	task automatic t_input();
		apb(1'b1, 12'h004, 32'h0000_0000);
		apb(1'b1, 12'h038, 32'h0000_00ff);
		probe_en  <= 8'hff;
		probe_val <= 8'h3c;
		settle(8);
		rd_chk("data_in", 12'h000, 32'h0000_003c);
		apb(1'b1, 12'h038, 32'h0000_000f);
		rd_chk("data_mix", 12'h000, 32'h0000_00ac);
		chk8("pin_ie_half", 8'h0f, pin_ie);
		$display("test gpio input done");
	endtask : t_input

	task automatic t_alt();
		apb(1'b1, 12'h038, 32'h0000_0000);
		apb(1'b1, 12'h008, 32'h0000_00ff);
		{swdio_out, tdo_out, trace_clock_out, trace_data_bit0, trace_data_bit1} <= 5'h1f;
		probe_en  <= 8'hd0;
		probe_val <= 8'h50;
		settle(8);
		chk8("alt_out_hi", 8'h2f, pin_out & 8'h2f);
		chk8("alt_oe", 8'h28, pin_oe);
		chk8("alt_ie", 8'h58, pin_ie);
		chk8("alt_pu", 8'hc8, pin_pu);
		chk8("alt_pd", 8'h10, pin_pd);
		chk8("dbg_in_a", 8'h0e, {4'h0, dbg_tms_in, dbg_tck_in, dbg_tdi_in, dbg_trst_n_in});
		@(posedge pclk);
		{swdio_out, tdo_out, trace_clock_out, trace_data_bit0, trace_data_bit1} <= 5'h00;
		probe_val <= 8'h80;
		settle(8);
		chk8("alt_out_lo", 8'h00, pin_out & 8'h2f);
		chk8("dbg_in_b", 8'h01, {4'h0, dbg_tms_in, dbg_tck_in, dbg_tdi_in, dbg_trst_n_in});
		$display("test alternate done");
	endtask : t_alt

	task automatic t_stop();
		apb(1'b1, 12'h004, 32'h0000_00ff);
		stop_mode          <= 1'b1;
		standby_drive_keep <= 1'b0;
		settle(3);
		chk8("stop_oe", 8'h08, pin_oe);
		@(posedge pclk);
		standby_drive_keep <= 1'b1;
		settle(3);
		chk8("stop_keep_oe", 8'hff, pin_oe);
		@(posedge pclk);
		standby_drive_keep <= 1'b0;
		apb(1'b1, 12'h008, 32'h0000_0000);
		settle(3);
		chk8("stop_gpio_oe", 8'h00, pin_oe);
		$display("test standby done");
	endtask : t_stop

	initial
	begin
		{presetn, psel, penable, pwrite, stop_mode, standby_drive_keep} = 6'h00;
		{swdio_out, tdo_out, trace_clock_out, trace_data_bit0, trace_data_bit1} = 5'h00;
		paddr     = 12'h000;
		pwdata    = 32'h0000_0000;
		probe_en  = 8'h00;
		probe_val = 8'h00;
		repeat (16) @(posedge pclk);
		presetn <= 1'b1;
		t_reset();
		t_regs();
		t_gpio_out();
		t_input();
		t_alt();
		t_stop();
		report_and_stop();
	end
endmodule : test_dgp_port
`default_nettype wire
